// *** rtl/lpdfc_regs.svh ***
// lpdfc_regs.svh: offsets, field positions and reset values of the
// lcd pin, duty and frame configuration block.
// assumes a 32-bit APB with byte addresses and one register a word.
// Functional notes
// - The group count field turns the forty drive pins into panel drivers by fours from the top; code zero (reset) leaves all as ports.
// - With expansion select clear the top four pins are ordinary drive pins under the group count.
// - With expansion select set the top four pins become the expander interface and the other groups still follow the count.
// - Static duty without mirror drives only the first common and frees the other three as ports.
// - Static duty with mirror drives all four commons, the second to fourth copying the first.
// - Half duty without mirror drives the first two commons and frees the third and fourth.
// - Half duty with mirror drives all four, the fourth copying the third and the second the first.
// - One-third duty without mirror drives three commons and frees the fourth.
// - One-third duty with mirror drives the fourth common with a non-select waveform.
// - Quarter duty drives all four commons whatever the mirror bit.
// - Frame clock select top bit clear takes the frame rate from the subclock: 128 Hz, 64 Hz, or 32 Hz when bit one is set; reset gives 128 Hz.
// - Frame clock select top bit set divides the system clock by 2 up to 256 as the low three bits ascend.
// - Display data control clear shows blank data and set shows the display RAM; reset is blank.
// - The controller is stopped while the run bit is clear and runs while it is set.
// - The bias resistor divider is off while its bit is clear and on while it is set.
`ifndef LPDFC_REGS_SVH
`define LPDFC_REGS_SVH

`define LPDFC_OFS_PIN_DUTY 12'h000
`define LPDFC_OFS_RUN_FRAME 12'h004

`define LPDFC_PIN_DUTY_RST 8'h00
`define LPDFC_RUN_FRAME_RST 8'h80
`define LPDFC_RUN_FRAME_WMASK 8'h7F

`define LPDFC_BIT_MIRROR 5
`define LPDFC_BIT_EXPAND 4
`define LPDFC_BIT_BIAS 6
`define LPDFC_BIT_RUN 5
`define LPDFC_BIT_SHOW 4
`define LPDFC_BIT_CLKSRC 3

`define LPDFC_GROUPS 11
`define LPDFC_MAX_COUNT 4'hA
`define LPDFC_SYS_DIV_W 8

`endif

// *** rtl/lpdfc_pkg.sv ***
// lpdfc_pkg.sv: types of the lcd pin, duty and frame configuration block.
// assumes the constants of lpdfc_regs.svh.
package lpdfc_pkg;

	typedef enum logic [1:0] {
		DUTY_STATIC,
		DUTY_HALF,
		DUTY_THIRD,
		DUTY_QUARTER
	} lpdfc_duty_t;

	typedef enum logic [1:0] {
		COM_OWN,
		COM_COPY_FIRST,
		COM_COPY_THIRD,
		COM_NON_SELECT
	} lpdfc_com_src_t;

	typedef struct packed {
		logic [3:0] drive_en;
		lpdfc_com_src_t [3:0] src;
	} lpdfc_com_cfg_t;

	typedef struct packed {
		logic [39:0] drive_en;
		logic expander_en;
	} lpdfc_seg_cfg_t;

endpackage

// *** rtl/lpdfc_top.sv ***
// lpdfc_top.sv: APB register slave and decode of the lcd pin, duty and
// frame configuration.
// assumes sub_clk is the watch subclock, sampled on pclk.
`timescale 1ns/10ps
`include "lpdfc_regs.svh"

module lpdfc_top (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock source
	input wire logic sub_clk,
	// panel configuration
	output lpdfc_pkg::lpdfc_seg_cfg_t seg_cfg,
	output lpdfc_pkg::lpdfc_com_cfg_t com_cfg,
	output lpdfc_pkg::lpdfc_duty_t duty,
	output logic frame_tick,
	output logic lcd_run,
	output logic show_ram_content,
	output logic bias_divider_on
);

	logic [7:0] pin_duty_q;
	logic [7:0] run_frame_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	lpdfc_pkg::lpdfc_seg_cfg_t seg_q;
	lpdfc_pkg::lpdfc_com_cfg_t com_q;
	lpdfc_pkg::lpdfc_com_cfg_t com_d;
	lpdfc_pkg::lpdfc_duty_t duty_q;
	logic frame_tick_q;
	logic frame_tick_d;
	logic run_q;
	logic show_q;
	logic bias_q;
	logic [`LPDFC_SYS_DIV_W-1:0] sys_div_q;
	logic [1:0] sub_div_q;
	logic sub_prev_q;
	logic sub_edge;
	logic setup;
	logic access;
	logic wr_pin_duty;
	logic wr_run_frame;

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == `LPDFC_OFS_PIN_DUTY) || (a == `LPDFC_OFS_RUN_FRAME);
	endfunction

	// group count code to number of driven groups
	function automatic logic [3:0] group_count(input logic [3:0] code);
		if (code[3]) begin
			group_count = 4'h9 + {3'h0, code[0]};
		end else if (code == 4'h0) begin
			group_count = 4'h0;
		end else begin
			group_count = code + 4'h1;
		end
	endfunction

	assign setup = psel && !penable;
	assign access = psel && penable && pready_q;
	assign wr_pin_duty = access && pwrite && paddr == `LPDFC_OFS_PIN_DUTY;
	assign wr_run_frame = access && pwrite && paddr == `LPDFC_OFS_RUN_FRAME;

	// bus answer: no wait state, data latched in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			pready_q <= 1'b1;
			pslverr_q <= !addr_hit(paddr);
			prdata_q <= 32'h0000_0000;
			if (!pwrite && paddr == `LPDFC_OFS_PIN_DUTY) begin
				prdata_q <= {24'h00_0000, pin_duty_q};
			end else if (!pwrite && paddr == `LPDFC_OFS_RUN_FRAME) begin
				prdata_q <= {24'h00_0000, run_frame_q};
			end
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_duty_q <= `LPDFC_PIN_DUTY_RST;
		end else if (wr_pin_duty) begin
			pin_duty_q <= pwdata[7:0];
		end
	end

	// top bit reads as one, not writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_frame_q <= `LPDFC_RUN_FRAME_RST;
		end else if (wr_run_frame) begin
			run_frame_q <= (pwdata[7:0] & `LPDFC_RUN_FRAME_WMASK)
				| ~`LPDFC_RUN_FRAME_WMASK;
		end
	end

	// segment pin assignment, group g covers pins 39-4g down to 36-4g
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_q <= '0;
		end else begin
			for (int g = 0; g < 10; g++) begin
				seg_q.drive_en[39-4*g -: 4] <=
					(g < int'(group_count(pin_duty_q[3:0]))) ? 4'hF : 4'h0;
			end
			if (pin_duty_q[`LPDFC_BIT_EXPAND]) begin
				seg_q.drive_en[39:36] <= 4'h0;
			end
			seg_q.expander_en <= pin_duty_q[`LPDFC_BIT_EXPAND];
		end
	end

	// common driver use
	always_comb begin
		com_d.drive_en = 4'hF;
		com_d.src = {4{lpdfc_pkg::COM_OWN}};
		case (lpdfc_pkg::lpdfc_duty_t'(pin_duty_q[7:6]))
			lpdfc_pkg::DUTY_STATIC: begin
				if (pin_duty_q[`LPDFC_BIT_MIRROR]) begin
					com_d.src[3] = lpdfc_pkg::COM_COPY_FIRST;
					com_d.src[2] = lpdfc_pkg::COM_COPY_FIRST;
					com_d.src[1] = lpdfc_pkg::COM_COPY_FIRST;
				end else begin
					com_d.drive_en = 4'h1;
				end
			end
			lpdfc_pkg::DUTY_HALF: begin
				if (pin_duty_q[`LPDFC_BIT_MIRROR]) begin
					com_d.src[3] = lpdfc_pkg::COM_COPY_THIRD;
					com_d.src[1] = lpdfc_pkg::COM_COPY_FIRST;
				end else begin
					com_d.drive_en = 4'h3;
				end
			end
			lpdfc_pkg::DUTY_THIRD: begin
				if (pin_duty_q[`LPDFC_BIT_MIRROR]) begin
					com_d.src[3] = lpdfc_pkg::COM_NON_SELECT;
				end else begin
					com_d.drive_en = 4'h7;
				end
			end
			lpdfc_pkg::DUTY_QUARTER: begin
				com_d.drive_en = 4'hF;
			end
			default: begin
				com_d.drive_en = 4'hF;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			com_q <= '0;
			duty_q <= lpdfc_pkg::DUTY_STATIC;
		end else begin
			com_q <= com_d;
			duty_q <= lpdfc_pkg::lpdfc_duty_t'(pin_duty_q[7:6]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			show_q <= 1'b0;
			bias_q <= 1'b0;
		end else begin
			run_q <= run_frame_q[`LPDFC_BIT_RUN];
			show_q <= run_frame_q[`LPDFC_BIT_SHOW];
			bias_q <= run_frame_q[`LPDFC_BIT_BIAS];
		end
	end

	// frame clock dividers, cleared while stopped
	assign sub_edge = sub_clk && !sub_prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_prev_q <= 1'b0;
			sub_div_q <= 2'h0;
			sys_div_q <= '0;
		end else begin
			sub_prev_q <= sub_clk;
			if (!run_frame_q[`LPDFC_BIT_RUN]) begin
				sub_div_q <= 2'h0;
				sys_div_q <= '0;
			end else begin
				sys_div_q <= sys_div_q + 1'b1;
				if (sub_edge) begin
					sub_div_q <= sub_div_q + 2'h1;
				end
			end
		end
	end

	always_comb begin
		frame_tick_d = 1'b0;
		if (run_frame_q[`LPDFC_BIT_RUN]) begin
			if (run_frame_q[`LPDFC_BIT_CLKSRC]) begin
				frame_tick_d = &(sys_div_q | ~((8'h02 <<
					run_frame_q[2:0]) - 8'h01));
			end else if (sub_edge) begin
				if (run_frame_q[1]) begin
					frame_tick_d = sub_div_q == 2'h3;
				end else if (run_frame_q[0]) begin
					frame_tick_d = sub_div_q[0];
				end else begin
					frame_tick_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_tick_q <= 1'b0;
		end else begin
			frame_tick_q <= frame_tick_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign seg_cfg = seg_q;
	assign com_cfg = com_q;
	assign duty = duty_q;
	assign frame_tick = frame_tick_q;
	assign lcd_run = run_q;
	assign show_ram_content = show_q;
	assign bias_divider_on = bias_q;

	sequence seq_cfg_written;
		wr_pin_duty ##2 1'b1;
	endsequence

	AST_SEG_ZERO_PORTS: assert property (@(posedge pclk) disable iff (!presetn)
		pin_duty_q[3:0] == 4'h0 |=> seg_q.drive_en == 40'h0)
		else $error("count zero left a drive pin on");

	AST_SEG_ALL: assert property (@(posedge pclk) disable iff (!presetn)
		pin_duty_q[3] && pin_duty_q[0] && !pin_duty_q[4]
		|=> seg_q.drive_en == 40'hFF_FFFF_FFFF)
		else $error("full count did not drive all pins");

	AST_SEG_TOP_PLAIN: assert property (@(posedge pclk) disable iff (!presetn)
		!pin_duty_q[4] && pin_duty_q[3:0] != 4'h0
		|=> seg_q.drive_en[39:36] == 4'hF && !seg_q.expander_en)
		else $error("top group not driven without expansion");

	AST_SEG_EXPAND: assert property (@(posedge pclk) disable iff (!presetn)
		seq_cfg_written |-> seg_q.expander_en == $past(pwdata[4], 2)
		&& (!seg_q.expander_en || seg_q.drive_en[39:36] == 4'h0))
		else $error("expander pins wrong after write");

	AST_COM_STATIC: assert property (@(posedge pclk) disable iff (!presetn)
		pin_duty_q[7:5] == 3'b000 |=> com_q.drive_en == 4'h1)
		else $error("static duty drove extra commons");

	AST_COM_STATIC_MIR: assert property (@(posedge pclk) disable iff (!presetn)
		pin_duty_q[7:5] == 3'b001 |=> com_q.drive_en == 4'hF
		&& com_q.src[2] == lpdfc_pkg::COM_COPY_FIRST)
		else $error("static mirror not copying first common");

	AST_COM_HALF: assert property (@(posedge pclk) disable iff (!presetn)
		pin_duty_q[7:5] == 3'b010 |=> com_q.drive_en == 4'h3)
		else $error("half duty common use wrong");

	AST_COM_HALF_MIR: assert property (@(posedge pclk) disable iff (!presetn)
		pin_duty_q[7:5] == 3'b011 |=> com_q.src[3] == lpdfc_pkg::COM_COPY_THIRD
		&& com_q.src[1] == lpdfc_pkg::COM_COPY_FIRST)
		else $error("half duty mirror wrong");

	AST_COM_THIRD: assert property (@(posedge pclk) disable iff (!presetn)
		pin_duty_q[7:6] == 2'b10 |=> com_q.drive_en ==
		($past(pin_duty_q[5]) ? 4'hF : 4'h7))
		else $error("third duty common use wrong");

	AST_COM_QUARTER: assert property (@(posedge pclk) disable iff (!presetn)
		pin_duty_q[7:6] == 2'b11 |=> com_q.drive_en == 4'hF)
		else $error("quarter duty not driving all commons");

	AST_SYS_DIV2: assert property (@(posedge pclk) disable iff (!presetn)
		frame_tick_q && run_frame_q[3:0] == 4'h8 && $stable(run_frame_q)
		|=> !frame_tick_q
		##1 (frame_tick_q || $past(run_frame_q[5:0]) != 6'h28))
		else $error("system clock by two not ticking");

	AST_STOP_NO_TICK: assert property (@(posedge pclk) disable iff (!presetn)
		!run_frame_q[5] [*2] |=> !frame_tick_q && !run_q)
		else $error("frame tick while stopped");

	AST_BLANK_BIAS: assert property (@(posedge pclk) disable iff (!presetn)
		wr_run_frame |=> ##1 show_q == $past(pwdata[4], 2)
		&& bias_q == $past(pwdata[6], 2))
		else $error("display or bias bit not followed");

	AST_SUB_128: assert property (@(posedge pclk) disable iff (!presetn)
		run_frame_q[5] && run_frame_q[3:0] == 4'h0 && sub_edge
		|=> frame_tick_q)
		else $error("subclock edge gave no tick at 128 Hz");

endmodule // lpdfc_top

// *** tb/lpdfc_sub_src.sv ***
// lpdfc_sub_src.sv: free-running watch subclock for the frame divider.
// assumes a pclk of 100 ns; phase offset keeps edges off pclk edges.
`timescale 1ns/10ps

module lpdfc_sub_src #(
	parameter int HALF_NS = 1000
) (
	// subclock
	output logic sub_clk
);
	initial begin
		sub_clk = 1'b0;
		#37;
		forever #(HALF_NS) sub_clk = ~sub_clk;
	end
endmodule // lpdfc_sub_src

// *** tb/tb.sv ***
// tb.sv: self-checking bench of lpdfc_top over APB.
// assumes lpdfc_sub_src gives a subclock period of 20 pclk cycles.
`timescale 1ns/10ps
`include "lpdfc_regs.svh"

module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic sub_clk, frame_tick, lcd_run, show_ram_content, bias_divider_on;
	lpdfc_pkg::lpdfc_seg_cfg_t seg_cfg;
	lpdfc_pkg::lpdfc_com_cfg_t com_cfg;
	lpdfc_pkg::lpdfc_duty_t duty;
	int err_count, total_checks, g;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [7:0] v;
	logic [3:0] en;
	lpdfc_pkg::lpdfc_com_src_t s[4];

	lpdfc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sub_clk(sub_clk), .seg_cfg(seg_cfg),
		.com_cfg(com_cfg), .duty(duty), .frame_tick(frame_tick),
		.lcd_run(lcd_run), .show_ram_content(show_ram_content),
		.bias_divider_on(bias_divider_on));
	lpdfc_sub_src sub (.sub_clk(sub_clk));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic check(input logic [40:0] seen, input logic [40:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one transfer; the expectation goes to the queue at setup
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [7:0] d, input logic [31:0] x, input logic xe);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'($urandom), d};
		exp_q.push_back({xe, wr, x});
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			check(1'b0, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			check(pslverr, e[33]);
			if (!e[32])
				check(prdata, e[31:0]);
		end
	end

	function automatic logic [39:0] seg_mask(input logic [4:0] c);
		logic [39:0] m;
		int n;
		m = '0;
		n = c[3] ? 9 + c[0] : (c[2:0] == 0 ? 0 : c[2:0] + 1);
		for (int i = 0; i < n; i++)
			m[39 - 4 * i -: 4] = 4'hF;
		if (c[4])
			m[39:36] = 4'h0;
		return m;
	endfunction

	// distance in cycles between two frame ticks
	task automatic gap(output int d);
		int n;
		n = 0;
		while (frame_tick !== 1'b1 && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		@(negedge pclk);
		d = 1;
		while (frame_tick !== 1'b1 && d < 3000) begin
			@(negedge pclk);
			d++;
		end
	endtask

	task automatic settle;
		repeat (3) @(negedge pclk);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		void'($urandom(32'h6bdc));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		check(seg_cfg, 41'h0);
		check({lcd_run, show_ram_content, bias_divider_on}, 3'h0);
		apb(0, `LPDFC_OFS_PIN_DUTY, 8'h00, 32'h0, 0);
		apb(0, `LPDFC_OFS_RUN_FRAME, 8'h00, 32'h80, 0);
		apb(1, 12'h008, 8'h5A, 32'h0, 1);
		apb(0, 12'h008, 8'h00, 32'h0, 1);
		apb(1, `LPDFC_OFS_RUN_FRAME, 8'h0F, 32'h0, 0);
		apb(0, `LPDFC_OFS_RUN_FRAME, 8'h00, 32'h8F, 0);
		for (int k = 0; k < 32; k++) begin
			v = {3'($urandom), k[4:0]};
			apb(1, `LPDFC_OFS_PIN_DUTY, v, 32'h0, 0);
			apb(0, `LPDFC_OFS_PIN_DUTY, 8'h00, {24'h0, v}, 0);
			settle();
			check(seg_cfg.drive_en, seg_mask(k[4:0]));
			check(seg_cfg.expander_en, k[4]);
		end
		for (int k = 0; k < 8; k++) begin
			apb(1, `LPDFC_OFS_PIN_DUTY, {k[2:0], 5'($urandom)}, 32'h0, 0);
			settle();
			en = (k[0] || k[2:1] == 3) ? 4'hF : (4'h2 << k[2:1]) - 4'h1;
			for (int i = 0; i < 4; i++)
				s[i] = lpdfc_pkg::COM_OWN;
			if (k == 1)
				for (int i = 1; i < 4; i++)
					s[i] = lpdfc_pkg::COM_COPY_FIRST;
			if (k == 3) begin
				s[1] = lpdfc_pkg::COM_COPY_FIRST;
				s[3] = lpdfc_pkg::COM_COPY_THIRD;
			end
			if (k == 5)
				s[3] = lpdfc_pkg::COM_NON_SELECT;
			check(duty, k[2:1]);
			check(com_cfg.drive_en, en);
			for (int i = 0; i < 4; i++)
				if (en[i])
					check(com_cfg.src[i], s[i]);
		end
		for (int k = 0; k < 12; k++) begin
			v = {1'b0, 1'($urandom), 1'b1, 1'($urandom),
				k < 8 ? {1'b1, k[2:0]} : {1'b0, 1'($urandom), k[1:0]}};
			apb(1, `LPDFC_OFS_RUN_FRAME, v, 32'h0, 0);
			settle();
			check({bias_divider_on, lcd_run, show_ram_content}, v[6:4]);
			gap(g);
			gap(g);
			if (k < 8)
				check(g, 2 << k);
			else
				check(g, 20 << (k[1] ? 2 : k[0]));
		end
		apb(1, `LPDFC_OFS_RUN_FRAME, 8'h48, 32'h0, 0);
		settle();
		check(lcd_run, 1'b0);
		g = 0;
		repeat (600) begin
			@(negedge pclk);
			if (frame_tick !== 1'b0)
				g++;
		end
		check(g, 0);
		results();
	end

	initial begin
		#3000000;
		err_count++;
		results();
	end
endmodule // tb
